//--- rtl/irqb_pkg.sv
package irqb_pkg;

  // ******************************************************************
  // Register map, byte offsets
  // ******************************************************************
  localparam logic [7:0] OFS_RELOAD   = 8'h00;  // Proximity timer reload
  localparam logic [7:0] OFS_THRESH   = 8'h04;  // Proximity threshold select
  localparam logic [7:0] OFS_STATUS   = 8'h08;  // Sticky event status, write 1 to clear
  localparam logic [7:0] OFS_MASK     = 8'h0C;  // Event mask
  localparam logic [7:0] OFS_TIMER    = 8'h10;  // Live proximity timer count
  localparam logic [7:0] OFS_CURRENT  = 8'h14;  // Arbitrated request

  // Windows of the word banks, selected by address bits 7:6
  localparam logic [1:0] WIN_CTRL     = 2'h0;
  localparam logic [1:0] WIN_FLAG     = 2'h1;
  localparam logic [1:0] WIN_ENABLE   = 2'h2;
  localparam logic [1:0] WIN_PRIO     = 2'h3;
  localparam int         WIN_HI       = 7;
  localparam int         WIN_LO       = 6;
  localparam int         IDX_HI       = 5;
  localparam int         IDX_LO       = 2;

  // ******************************************************************
  // Field layouts
  // ******************************************************************
  localparam int         DATA_W       = 32;
  localparam int         PRIO_W       = 3;
  localparam int         SUB_W        = 2;
  localparam int         SLOT_STRIDE  = 8;
  localparam int         SLOTS_PER_W  = 4;
  localparam int         PRIO_LSB     = 2;
  localparam int         SUB_LSB      = 0;
  localparam logic [31:0] PRIO_IMPL_MASK = 32'h1F1F_1F1F;
  localparam logic [2:0] PRIO_OFF     = 3'h0;

  // Status and mask bit positions
  localparam int         EV_REQUEST   = 0;
  localparam int         EV_TIMEOUT   = 1;
  localparam int         EV_W         = 2;

  // Current-request word layout
  localparam int         CUR_VALID    = 31;
  localparam int         CUR_PRIO_LSB = 16;
  localparam int         CUR_SUB_LSB  = 8;

  // ******************************************************************
  // Reset values and bus codes
  // ******************************************************************
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

//--- rtl/irqb_arbiter.sv
`timescale 1ns/1ps

// ********************************************************************
// Picks the highest requesting source and spots proximity starts
// ********************************************************************
module irqb_arbiter #(
  parameter int NUM_SRC = 64,
  parameter int SRC_W   = 6
) (
  // Banks
  input  wire logic [NUM_SRC-1:0]              i_flag,
  input  wire logic [NUM_SRC-1:0]              i_enable,
  input  wire logic [NUM_SRC/4-1:0][31:0]      i_prio,
  // Proximity start
  input  wire logic [NUM_SRC-1:0]              i_event,
  input  wire logic [2:0]                      i_thresh,
  // Result
  output logic                                 o_valid,
  output logic [SRC_W-1:0]                     o_src,
  output logic [2:0]                           o_prio,
  output logic [1:0]                           o_sub,
  output logic                                 o_prox_start
);

  logic [NUM_SRC-1:0][2:0] pri;
  logic [NUM_SRC-1:0][1:0] sub;
  logic [NUM_SRC-1:0]      req;
  logic [NUM_SRC-1:0]      hit;

  // Per-source field extraction from the packed priority words
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    localparam int W  = s / irqb_pkg::SLOTS_PER_W;
    localparam int PB = (s % irqb_pkg::SLOTS_PER_W) * irqb_pkg::SLOT_STRIDE;
    assign pri[s] = i_prio[W][PB+irqb_pkg::PRIO_LSB +: irqb_pkg::PRIO_W];
    assign sub[s] = i_prio[W][PB+irqb_pkg::SUB_LSB +: irqb_pkg::SUB_W];
    // Priority zero means disabled, whatever the enable bit says
    assign req[s] = i_flag[s] & i_enable[s] & (pri[s] != irqb_pkg::PRIO_OFF);
    // Threshold N starts the timer for group priority N or lower
    assign hit[s] = i_event[s] & i_enable[s] & (pri[s] != irqb_pkg::PRIO_OFF)
                    & (pri[s] <= i_thresh);
  end

  // Highest priority, then subpriority; lowest index wins a full tie
  always_comb begin
    o_valid = 1'b0;
    o_src   = '0;
    o_prio  = '0;
    o_sub   = '0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (req[s] && (!o_valid || {pri[s], sub[s]} >= {o_prio, o_sub})) begin
        o_valid = 1'b1;
        o_src   = SRC_W'(s);
        o_prio  = pri[s];
        o_sub   = sub[s];
      end
    end
  end

  assign o_prox_start = (i_thresh != irqb_pkg::PRIO_OFF) && (|hit);

endmodule // irqb_arbiter

//--- rtl/irqb_bank.sv
`timescale 1ns/1ps

// Operation
// - A 32-bit writable reload value is loaded into the proximity timer on each start.
// - Each flag word holds 32 per-source bits that read 1 once a request has occurred.
// - Each enable word holds 32 per-source bits, 1 enabling and 0 disabling the source.
// - A 3-bit priority field codes levels 1 to 7 directly and 000 bars the source from arbitration and proximity starts.
// - A 2-bit subpriority field codes 0 (lowest) to 3 (highest) directly.
// - Slot 3 of a priority word has priority at bits 28:26 and subpriority at 25:24.
// - Slot 2 of a priority word has priority at bits 20:18 and subpriority at 17:16.
// - Slot 1 of a priority word has its priority field at bits 12:10.
// - Bits 31:29, 23:21 and 15:13 of a priority word ignore writes and read zero.
// - Reload, flag, enable and priority words are all zero after reset.
// - Slot 0 of a priority word has priority at bits 4:2 and subpriority at 1:0.
// - Slot 1 of a priority word has its subpriority at bits 9:8, coded 0 to 3.
// - A 3-bit threshold lets group priority N or lower start the proximity timer.

module irqb_bank #(
  parameter int NUM_SRC = 64
) (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset_n,
  // AHB-Lite slave
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic [31:0]               o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  // Interrupt sources, one-cycle pulses on this clock
  input  wire logic [NUM_SRC-1:0]   i_src_event,
  // Request to the core
  output logic                      o_req_valid,
  output logic [$clog2(NUM_SRC)-1:0] o_req_src,
  output logic [2:0]                o_req_prio,
  output logic [1:0]                o_req_sub,
  output logic                      o_timer_run,
  // Event interrupt
  output logic                      o_irq
);

  // ******************************************************************
  // Sizes and state
  // ******************************************************************
  localparam int SRC_W     = $clog2(NUM_SRC);
  localparam int NUM_WORDS = NUM_SRC / irqb_pkg::DATA_W;
  localparam int NUM_PW    = NUM_SRC / irqb_pkg::SLOTS_PER_W;
  localparam int IDX_W     = irqb_pkg::IDX_HI - irqb_pkg::IDX_LO + 1;

  typedef struct packed {
    logic [31:0]                 reload;
    logic [2:0]                  thresh;
    logic [irqb_pkg::EV_W-1:0]   status;
    logic [irqb_pkg::EV_W-1:0]   mask;
    logic [31:0]                 timer;
    logic                        timer_run;
    logic [NUM_WORDS-1:0][31:0]  flag;
    logic [NUM_WORDS-1:0][31:0]  enable;
    logic [NUM_PW-1:0][31:0]     prio;
    logic                        wr_pend;
    logic [7:0]                  wr_addr;
    logic [31:0]                 hrdata;
    logic                        hready;
    logic                        irq;
    logic                        req_valid;
    logic [SRC_W-1:0]            req_src;
    logic [2:0]                  req_prio;
    logic [1:0]                  req_sub;
  } irqb_state_t;

  irqb_state_t st_q;
  irqb_state_t st_d;

  // ******************************************************************
  // Arbitration on the stored banks
  // ******************************************************************
  logic             arb_valid;
  logic [SRC_W-1:0] arb_src;
  logic [2:0]       arb_prio;
  logic [1:0]       arb_sub;
  logic             prox_start;
  logic [NUM_SRC-1:0] new_req;

  irqb_arbiter #(
    .NUM_SRC (NUM_SRC),
    .SRC_W   (SRC_W)
  ) u_arb (
    .i_flag       (st_q.flag),
    .i_enable     (st_q.enable),
    .i_prio       (st_q.prio),
    .i_event      (i_src_event),
    .i_thresh     (st_q.thresh),
    .o_valid      (arb_valid),
    .o_src        (arb_src),
    .o_prio       (arb_prio),
    .o_sub        (arb_sub),
    .o_prox_start (prox_start)
  );

  // A source event counts as new when its source is enabled and its flag was still clear
  assign new_req = i_src_event & ~st_q.flag & st_q.enable;

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  logic             addr_phase;
  logic             rd_take;
  logic             wr_take;
  logic [1:0]       wr_win;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0]      wr_data;
  logic [1:0]       rd_win;
  logic [IDX_W-1:0] rd_idx;

  // Only whole-word writes touch the registers; reads are taken at any size
  assign addr_phase = i_hsel & i_hready & i_htrans[1];
  assign rd_take    = addr_phase & ~i_hwrite;
  assign wr_take    = addr_phase & i_hwrite & (i_hsize == irqb_pkg::HSIZE_WORD);
  assign wr_win     = st_q.wr_addr[irqb_pkg::WIN_HI:irqb_pkg::WIN_LO];
  assign wr_idx     = st_q.wr_addr[irqb_pkg::IDX_HI:irqb_pkg::IDX_LO];
  assign wr_data    = i_hwdata;
  assign rd_win     = i_haddr[irqb_pkg::WIN_HI:irqb_pkg::WIN_LO];
  assign rd_idx     = i_haddr[irqb_pkg::IDX_HI:irqb_pkg::IDX_LO];

  // ******************************************************************
  // Next state
  // ******************************************************************
  // Read data other than OFS_CURRENT is built from the next state, so a read
  // right after a write to the same word already sees the written value.
  always_comb begin
    logic [irqb_pkg::EV_W-1:0] ev;
    logic [irqb_pkg::EV_W-1:0] w1c;
    logic [31:0]               rd;
    ev  = '0;
    w1c = '0;
    rd  = irqb_pkg::ZERO_WORD;
    st_d = st_q;

    // Data phase of a write taken on the previous edge
    st_d.wr_pend = wr_take;
    st_d.wr_addr = i_haddr[7:0];
    if (st_q.wr_pend) begin
      unique case (wr_win)
        irqb_pkg::WIN_CTRL: begin
          unique case (st_q.wr_addr)
            irqb_pkg::OFS_RELOAD: st_d.reload = wr_data;
            irqb_pkg::OFS_THRESH: st_d.thresh = wr_data[2:0];
            irqb_pkg::OFS_STATUS: w1c = wr_data[irqb_pkg::EV_W-1:0];
            irqb_pkg::OFS_MASK:   st_d.mask = wr_data[irqb_pkg::EV_W-1:0];
            default: ;  // Read-only or unmapped: ignored
          endcase
        end
        irqb_pkg::WIN_FLAG: begin
          // Zero clears after service; a one may also raise it by software
          if (int'(wr_idx) < NUM_WORDS) st_d.flag[wr_idx] = wr_data;
        end
        irqb_pkg::WIN_ENABLE: begin
          if (int'(wr_idx) < NUM_WORDS) st_d.enable[wr_idx] = wr_data;
        end
        irqb_pkg::WIN_PRIO: begin
          // Unimplemented bit groups are dropped on write
          if (int'(wr_idx) < NUM_PW) begin
            st_d.prio[wr_idx] = wr_data & irqb_pkg::PRIO_IMPL_MASK;
          end
        end
      endcase
    end

    // Source events set their flags; a set beats a same-cycle clear
    st_d.flag = st_d.flag | i_src_event;

    // Proximity timer: every start reloads it, then it counts down
    if (prox_start) begin
      st_d.timer     = st_q.reload;
      st_d.timer_run = (st_q.reload != irqb_pkg::ZERO_WORD);
    end else if (st_q.timer_run) begin
      st_d.timer = st_q.timer - 32'h0000_0001;
      if (st_q.timer == 32'h0000_0001) begin
        st_d.timer_run = 1'b0;
        ev[irqb_pkg::EV_TIMEOUT] = 1'b1;
      end
    end

    // Sticky status: hardware set wins over the write-one clear
    ev[irqb_pkg::EV_REQUEST] = |new_req;
    st_d.status = (st_q.status & ~w1c) | ev;
    st_d.irq    = |(st_d.status & st_d.mask);

    // Arbitrated request registered for the core
    st_d.req_valid = arb_valid;
    st_d.req_src   = arb_src;
    st_d.req_prio  = arb_prio;
    st_d.req_sub   = arb_sub;

    // Read mux; unmapped addresses read zero
    unique case (rd_win)
      irqb_pkg::WIN_CTRL: begin
        unique case (i_haddr[7:0])
          irqb_pkg::OFS_RELOAD: rd = st_d.reload;
          irqb_pkg::OFS_THRESH: rd = {29'h0000_0000, st_d.thresh};
          irqb_pkg::OFS_STATUS: rd = {30'h0000_0000, st_d.status};
          irqb_pkg::OFS_MASK:   rd = {30'h0000_0000, st_d.mask};
          irqb_pkg::OFS_TIMER:  rd = st_d.timer;
          irqb_pkg::OFS_CURRENT: begin
            rd[irqb_pkg::CUR_VALID] = st_q.req_valid;
            rd[irqb_pkg::CUR_PRIO_LSB +: 3] = st_q.req_prio;
            rd[irqb_pkg::CUR_SUB_LSB +: 2]  = st_q.req_sub;
            rd[SRC_W-1:0] = st_q.req_src;
          end
          default: rd = irqb_pkg::ZERO_WORD;
        endcase
      end
      irqb_pkg::WIN_FLAG: begin
        if (int'(rd_idx) < NUM_WORDS) rd = st_d.flag[rd_idx];
      end
      irqb_pkg::WIN_ENABLE: begin
        if (int'(rd_idx) < NUM_WORDS) rd = st_d.enable[rd_idx];
      end
      irqb_pkg::WIN_PRIO: begin
        if (int'(rd_idx) < NUM_PW) rd = st_d.prio[rd_idx];
      end
    endcase
    st_d.hrdata = rd_take ? rd : st_q.hrdata;
    st_d.hready = 1'b1;  // Zero wait states
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  // All banks clear at reset; the bus stays ready throughout
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_q        <= '0;
      st_q.hready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ******************************************************************
  // Outputs, all but o_hresp straight from flops; o_hresp is tied to OKAY
  // ******************************************************************
  assign o_hrdata    = st_q.hrdata;
  assign o_hreadyout = st_q.hready;
  assign o_hresp     = irqb_pkg::HRESP_OKAY;
  assign o_req_valid = st_q.req_valid;
  assign o_req_src   = st_q.req_src;
  assign o_req_prio  = st_q.req_prio;
  assign o_req_sub   = st_q.req_sub;
  assign o_timer_run = st_q.timer_run;
  assign o_irq       = st_q.irq;

endmodule // irqb_bank

//--- tb/irqb_bank_sva.sv
`timescale 1ns/1ps

// ******************************************************************
// Port checks for the interrupt register bank
// ******************************************************************
module irqb_bank_sva #(
  parameter int NUM_SRC = 64
) (
  // Clock, reset and bus
  input wire logic                       i_clk_sys,
  input wire logic                       i_reset_n,
  input wire logic                       i_hsel,
  input wire logic [31:0]                i_haddr,
  input wire logic [1:0]                 i_htrans,
  input wire logic                       i_hwrite,
  input wire logic [2:0]                 i_hsize,
  input wire logic [31:0]                i_hwdata,
  input wire logic                       i_hready,
  input wire logic [31:0]                o_hrdata,
  input wire logic                       o_hreadyout,
  input wire logic                       o_hresp,
  // Sources and request
  input wire logic [NUM_SRC-1:0]         i_src_event,
  input wire logic                       o_req_valid,
  input wire logic [$clog2(NUM_SRC)-1:0] o_req_src,
  input wire logic [2:0]                 o_req_prio,
  input wire logic [1:0]                 o_req_sub,
  input wire logic                       o_timer_run,
  input wire logic                       o_irq
);
  logic       rd_w;
  logic       wr_w;
  logic       ev_any;
  logic [3:0] act_q;
  logic [3:0] act_d;

  // Taken transfers and a four-edge activity history
  assign rd_w = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
  assign wr_w = i_hsel & i_hready & i_htrans[1] & i_hwrite;
  assign ev_any = |i_src_event;
  always_comb act_d = {act_q[2:0], wr_w | (|i_src_event)};
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) act_q <= 4'h0;
    else act_q <= act_d;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence s_prio_rd;
    rd_w && i_haddr[7:6] == irqb_pkg::WIN_PRIO;
  endsequence
  sequence s_hole_rd;
    rd_w && i_haddr[7:0] >= 8'h18 && i_haddr[7:0] < 8'h40;
  endsequence

  AST_RESET_CLEAR: assert property ($rose(i_reset_n) |-> o_hrdata == 32'h0000_0000
    && !o_irq && !o_req_valid && !o_timer_run) else $error("state not clear after reset");
  AST_BUS_OKAY: assert property (o_hresp == irqb_pkg::HRESP_OKAY && o_hreadyout)
    else $error("bus response not ready okay");
  AST_PRIO_NONZERO: assert property (o_req_valid |-> o_req_prio != 3'h0)
    else $error("request with priority zero");
  AST_PRIO_RSVD: assert property (s_prio_rd |=> (o_hrdata & ~irqb_pkg::PRIO_IMPL_MASK) == 0)
    else $error("reserved priority bits read nonzero");
  AST_HOLE_ZERO: assert property (s_hole_rd |=> o_hrdata == 32'h0000_0000)
    else $error("unmapped read nonzero");
  AST_HRDATA_HOLD: assert property (!$past(rd_w) |-> $stable(o_hrdata))
    else $error("read data moved without a read");
  AST_FLAG_STICKY: assert property ($fell(o_req_valid)
    |-> $past(wr_w, 2) || $past(wr_w, 3) || $past(wr_w, 4)) else $error("request dropped unasked");
  AST_TIMER_START: assert property ($rose(o_timer_run) |-> $past(ev_any))
    else $error("timer started without event");
  AST_REQ_STABLE: assert property ((act_q == 4'h0 && o_req_valid)
    |-> $stable(o_req_src) && $stable(o_req_prio)) else $error("winner moved while quiet");
  AST_IRQ_HOLD: assert property ((act_q == 4'h0 && !$past(o_timer_run, 2))
    |-> $stable(o_irq)) else $error("irq moved while quiet");
endmodule // irqb_bank_sva

bind irqb_bank irqb_bank_sva #(.NUM_SRC(NUM_SRC)) u_sva (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_src_event(i_src_event), .o_req_valid(o_req_valid), .o_req_src(o_req_src),
  .o_req_prio(o_req_prio), .o_req_sub(o_req_sub), .o_timer_run(o_timer_run), .o_irq(o_irq));

//--- tb/irqb_src_model.sv
`timescale 1ns/1ps

// ******************************************************************
// Peripheral sources: one pulse per rising request level
// ******************************************************************
module irqb_src_model #(
  parameter int NUM_SRC = 64
) (
  // Clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset_n,
  // Request levels in, pulses out
  input  wire logic [NUM_SRC-1:0] i_req,
  output logic [NUM_SRC-1:0]      o_event
);
  logic [NUM_SRC-1:0] req_q;

  // Edge detect so a held level never floods the flags
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      req_q   <= '0;
      o_event <= '0;
    end else begin
      req_q   <= i_req;
      o_event <= i_req & ~req_q;
    end
  end
endmodule // irqb_src_model

//--- tb/irqb_bank_test.sv
`timescale 1ns/1ps

// ******************************************************************
// Self-checking bench for the interrupt register bank
// ******************************************************************
module irqb_bank_test;
  localparam int NS = 64;
  logic          i_clk_sys = 1'b0;
  logic          i_reset_n = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h0000_0000;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [2:0]    hsize = irqb_pkg::HSIZE_WORD;
  logic [31:0]   hwdata = 32'h0000_0000;
  logic [31:0]   hrdata;
  logic [31:0]   rdv;
  logic          hready;
  logic [NS-1:0] src_req = '0;
  logic [NS-1:0] src_event;
  logic          req_valid;
  logic [5:0]    req_src;
  logic [2:0]    req_prio;
  logic [1:0]    req_sub;
  logic          timer_run;
  logic          irq;
  int            bad_count = 0;
  int            checks = 0;
  int            cycles = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  irqb_src_model #(.NUM_SRC(NS)) u_src (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_req(src_req), .o_event(src_event));
  irqb_bank #(.NUM_SRC(NS)) u_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(), .i_src_event(src_event), .o_req_valid(req_valid), .o_req_src(req_src),
    .o_req_prio(req_prio), .o_req_sub(req_sub), .o_timer_run(timer_run), .o_irq(irq));

  // Word address of a bank window, or of a control offset
  function automatic logic [31:0] wa(input logic [1:0] win, input int idx);
    return {24'h0000_00, win, idx[3:0], 2'b00};
  endfunction
  function automatic logic [31:0] ca(input logic [7:0] ofs);
    return {24'h0000_00, ofs};
  endfunction

  // One AHB transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= irqb_pkg::HTRANS_NONSEQ;
    do @(posedge i_clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk_sys); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk_word(rdv, e);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_req(input logic [11:0] exp);
    chk_word({20'h0_0000, req_valid, req_prio, req_sub, req_src}, {20'h0_0000, exp});
  endtask
  // Raise source requests for one cycle, then let flag and winner settle
  task automatic fire(input logic [NS-1:0] m);
    src_req <= m;
    @(posedge i_clk_sys);
    src_req <= '0;
    repeat (3) @(posedge i_clk_sys);
  endtask

  task automatic t_reset();
    logic [31:0] al [10] = '{ca(8'h00), ca(8'h04), ca(8'h08), ca(8'h0C), ca(8'h14),
      wa(2'h1, 0), wa(2'h1, 1), wa(2'h2, 1), wa(2'h3, 0), wa(2'h3, 15)};
    foreach (al[i]) rd_chk(al[i], 32'h0000_0000);
    $display("t_reset done");
  endtask

  task automatic t_regs();
    wr(ca(irqb_pkg::OFS_RELOAD), 32'hA5A5_5A5A);
    rd_chk(ca(irqb_pkg::OFS_RELOAD), 32'hA5A5_5A5A);
    // A byte-sized write must leave the word alone
    hsize <= 3'h0;
    wr(ca(irqb_pkg::OFS_RELOAD), 32'h0000_FFFF);
    hsize <= irqb_pkg::HSIZE_WORD;
    rd_chk(ca(irqb_pkg::OFS_RELOAD), 32'hA5A5_5A5A);
    wr(wa(2'h2, 1), 32'hFFFF_0001);
    rd_chk(wa(2'h2, 1), 32'hFFFF_0001);
    wr(wa(2'h1, 0), 32'h8000_0001);
    rd_chk(wa(2'h1, 0), 32'h8000_0001);
    wr(wa(2'h3, 0), 32'hFFFF_FFFF);
    rd_chk(wa(2'h3, 0), 32'h1F1F_1F1F);
    wr(ca(8'h20), 32'hFFFF_FFFF);
    rd_chk(ca(8'h20), 32'h0000_0000);
    wr(wa(2'h1, 0), 32'h0000_0000);
    wr(wa(2'h3, 0), 32'h0000_0000);
    wr(wa(2'h2, 1), 32'h0000_0000);
    $display("t_regs done");
  endtask

  // Each slot of priority word 1 in turn, via sources 4 to 7
  task automatic t_slots();
    logic [2:0]  p;
    logic [1:0]  s;
    logic [31:0] v;
    for (int k = 0; k < 4; k++) begin
      p = 3'(k + 4);
      s = 2'(3 - k);
      v = {27'h000_0000, p, s} << (8 * k);
      wr(wa(2'h3, 1), v);
      rd_chk(wa(2'h3, 1), v);
      wr(wa(2'h2, 0), 32'h0000_0001 << (4 + k));
      fire(NS'(1) << (4 + k));
      chk_req({1'b1, p, s, 6'(4 + k)});
      wr(wa(2'h1, 0), 32'h0000_0000);
      repeat (2) @(posedge i_clk_sys);
      chk_req(12'h000);
    end
    $display("t_slots done");
  endtask

  task automatic t_arbit();
    wr(wa(2'h2, 0), 32'h0000_0003);
    wr(wa(2'h3, 0), 32'h0000_0900);
    fire(NS'(3));
    chk_req({1'b1, 3'h2, 2'h1, 6'h01});
    wr(wa(2'h3, 0), 32'h0000_090B);
    repeat (2) @(posedge i_clk_sys);
    chk_req({1'b1, 3'h2, 2'h3, 6'h00});
    wr(wa(2'h2, 0), 32'h0000_0002);
    repeat (22) @(posedge i_clk_sys);
    chk_req({1'b1, 3'h2, 2'h1, 6'h01});
    wr(wa(2'h2, 0), 32'h0000_0000);
    repeat (2) @(posedge i_clk_sys);
    chk_req(12'h000);
    rd_chk(wa(2'h1, 0), 32'h0000_0003);
    wr(wa(2'h1, 0), 32'h0000_0000);
    $display("t_arbit done");
  endtask

  task automatic t_irq();
    // Earlier tests left sticky status set; start from clear
    wr(ca(irqb_pkg::OFS_STATUS), 32'h0000_0003);
    wr(ca(irqb_pkg::OFS_MASK), 32'h0000_0003);
    wr(ca(irqb_pkg::OFS_THRESH), 32'h0000_0003);
    wr(ca(irqb_pkg::OFS_RELOAD), 32'h0000_0005);
    wr(wa(2'h3, 0), 32'h0000_1C0C);
    wr(wa(2'h2, 0), 32'h0000_0003);
    fire(NS'(2));
    chk_word({30'h0, timer_run, irq}, 32'h0000_0001);
    rd_chk(ca(irqb_pkg::OFS_STATUS), 32'h0000_0001);
    wr(ca(irqb_pkg::OFS_STATUS), 32'h0000_0001);
    rd_chk(ca(irqb_pkg::OFS_STATUS), 32'h0000_0000);
    chk_word({31'h0, irq}, 32'h0000_0000);
    fire(NS'(1));
    chk_word({30'h0, timer_run, irq}, 32'h0000_0003);
    // Reload 5: runs five cycles from the start edge, then stops
    repeat (3) @(posedge i_clk_sys);
    chk_word({31'h0, timer_run}, 32'h0000_0001);
    @(posedge i_clk_sys);
    chk_word({31'h0, timer_run}, 32'h0000_0000);
    rd_chk(ca(irqb_pkg::OFS_STATUS), 32'h0000_0003);
    wr(ca(irqb_pkg::OFS_MASK), 32'h0000_0000);
    repeat (2) @(posedge i_clk_sys);
    chk_word({31'h0, irq}, 32'h0000_0000);
    wr(ca(irqb_pkg::OFS_STATUS), 32'h0000_0003);
    wr(wa(2'h1, 0), 32'h0000_0000);
    $display("t_irq done");
  endtask

  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog well above the few hundred cycles the tests need
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    @(posedge i_clk_sys);
    t_reset();
    t_regs();
    t_slots();
    t_arbit();
    t_irq();
    finish_test();
  end
endmodule // irqb_bank_test
